// ### hdl/sram_ctrl.sv
// Host-side controller for a 64K x 16 asynchronous static memory.
// Assumes the memory data pins are resolved outside from dq_o/dq_oe.
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_map.svh"
module sram_ctrl
  import sram_port_pkg::*;
(
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  arst_n,
  // Request port
  input  wire logic  req_valid,
  input  wire logic  req_write,
  input  wire addr_t req_addr,
  input  wire data_t req_wdata,
  input  wire logic [1:0] req_lanes,
  output var  logic  req_ready,
  output var  logic  rsp_valid,
  output var  data_t rsp_rdata,
  // Retention control
  input  wire logic  sleep_req,
  output var  logic  asleep,
  // Memory pins
  output var  logic  mem_cs_n,
  output var  logic  mem_we_n,
  output var  logic  mem_oe_n,
  output var  logic  upper_lane_enable_n,
  output var  logic  lower_lane_enable_n,
  output var  addr_t mem_addr,
  output var  data_t mem_dq_o,
  output var  logic [1:0] mem_dq_oe,
  input  wire data_t mem_dq_i
);
  sram_pin_if pin ();

  // ----------------------------------------------------------------------------
  // State and counters
  // ----------------------------------------------------------------------------
  ctl_state_e st_r, st_nxt;
  cnt_t       cnt_r, cnt_nxt;
  addr_t      addr_r;
  data_t      wdata_r;
  logic [1:0] lanes_r;
  data_t      dq_s1_r, dq_s2_r;
  logic       sleep_s1_r, sleep_s2_r;

  localparam cnt_t READ_N  = cnt_t'(`READ_CYC);
  localparam cnt_t WRITE_N = cnt_t'(`WRITE_CYC);
  localparam cnt_t TURN_N  = cnt_t'(`TURN_CYC);
  localparam cnt_t WAKE_N  = cnt_t'(`RECOVER_CYC);

  // Read samples via two flops, so add two cycles of margin
  wire cnt_done  = (cnt_r == 4'h0);
  wire take      = (st_r == ST_IDLE) && req_valid && (req_lanes != 2'h0) && !sleep_s2_r;
  wire in_access = (st_r == ST_READ) || (st_r == ST_WSET) || (st_r == ST_WRITE) || (st_r == ST_WEND);

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_done ? 4'h0 : cnt_r - 4'h1;
    unique case (st_r)
      ST_IDLE: begin
        if (sleep_s2_r) begin
          st_nxt = ST_SLEEP;
        end else if (take) begin
          st_nxt  = req_write ? ST_WSET : ST_READ;
          cnt_nxt = req_write ? 4'h0 : READ_N + 4'h2;
        end
      end
      ST_READ: begin
        if (cnt_done) begin
          st_nxt  = ST_TURN;
          cnt_nxt = TURN_N;
        end
      end
      ST_WSET: begin
        st_nxt  = ST_WRITE;
        cnt_nxt = WRITE_N - 4'h1;
      end
      ST_WRITE: begin
        if (cnt_done) begin
          st_nxt = ST_WEND;
        end
      end
      ST_WEND: begin
        st_nxt = ST_IDLE;
      end
      ST_TURN: begin
        if (cnt_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (!sleep_s2_r) begin
          st_nxt  = ST_WAKE;
          cnt_nxt = WAKE_N;
        end
      end
      ST_WAKE: begin
        if (cnt_done) begin
          st_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r    <= ST_IDLE;
      cnt_r   <= 4'h0;
      addr_r  <= 16'h0000;
      wdata_r <= 16'h0000;
      lanes_r <= 2'h0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      if (take) begin
        addr_r  <= req_addr;
        wdata_r <= req_wdata;
        lanes_r <= req_lanes;
      end
    end
  end

  // Read data and sleep request come from outside the clock domain
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dq_s1_r    <= 16'h0000;
      dq_s2_r    <= 16'h0000;
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
    end else begin
      dq_s1_r    <= mem_dq_i;
      dq_s2_r    <= dq_s1_r;
      sleep_s1_r <= sleep_req;
      sleep_s2_r <= sleep_s1_r;
    end
  end

  // ----------------------------------------------------------------------------
  // Pin values; the pin stage registers them once more
  // ----------------------------------------------------------------------------
  // Lanes stay high outside accesses so they never toggle while deselected
  assign pin.cs_n  = !in_access;
  assign pin.we_n  = !(st_r == ST_WRITE);
  assign pin.oe_n  = !(st_r == ST_READ);
  assign pin.upper_lane_enable_n = !(in_access && lanes_r[1]);
  assign pin.lower_lane_enable_n = !(in_access && lanes_r[0]);
  assign pin.addr  = addr_r;
  assign pin.wdata = wdata_r;
  // Data driven one cycle either side of the strobe: zero hold is met with margin
  assign pin.drive = (st_r == ST_WSET) || (st_r == ST_WRITE) || (st_r == ST_WEND);

  sram_pin_stage u_pins (
    .mclk                (mclk),
    .arst_n              (arst_n),
    .p                   (pin),
    .mem_cs_n            (mem_cs_n),
    .mem_we_n            (mem_we_n),
    .mem_oe_n            (mem_oe_n),
    .upper_lane_enable_n (upper_lane_enable_n),
    .lower_lane_enable_n (lower_lane_enable_n),
    .mem_addr            (mem_addr),
    .mem_dq_o            (mem_dq_o),
    .mem_dq_oe           (mem_dq_oe)
  );

  // ----------------------------------------------------------------------------
  // User-side outputs, all registered
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      asleep    <= 1'b0;
    end else begin
      req_ready <= (st_nxt == ST_IDLE) && !take;
      rsp_valid <= (st_r == ST_READ) && cnt_done;
      if ((st_r == ST_READ) && cnt_done) begin
        rsp_rdata <= {lanes_r[1] ? dq_s2_r[15:8] : 8'h00, lanes_r[0] ? dq_s2_r[7:0] : 8'h00};
      end
      asleep <= (st_nxt == ST_SLEEP);
    end
  end
endmodule
`default_nettype wire

// ### hdl/sram_port_map.svh
// Offsets-free timing and width constants for the static memory controller.
// Assumes a 40 MHz mclk (25 ns period); counts round least times up.
`ifndef SRAM_PORT_MAP_SVH
`define SRAM_PORT_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and array geometry
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS                   25
`define ADDR_W                          16
`define DATA_W                          16

// ----------------------------------------------------------------------------
// Times in ns (slow grade, which also covers the fast grade)
// ----------------------------------------------------------------------------
`define READ_CYCLE_TIME_NS              55
`define ADDRESS_ACCESS_DELAY_NS         55
`define OUTPUT_ENABLE_ACCESS_DELAY_NS   25
`define WRITE_DATA_SETUP_NS             25
`define ADDRESS_SETUP_TO_WRITE_END_NS   40
`define WRITE_PULSE_WIDTH_NS            40
`define BUS_TURNAROUND_NS               20
`define DESELECT_TO_POWERDOWN_NS        55

// ----------------------------------------------------------------------------
// Cycle counts, rounded up, at least one
// ----------------------------------------------------------------------------
`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYC      `NS_TO_CYC(`READ_CYCLE_TIME_NS)
`define WRITE_CYC     `NS_TO_CYC(`WRITE_PULSE_WIDTH_NS)
`define TURN_CYC      `NS_TO_CYC(`BUS_TURNAROUND_NS)
`define RECOVER_CYC   `NS_TO_CYC(`READ_CYCLE_TIME_NS)

`endif

// ### hdl/sram_port_pkg.sv
// Types shared by the static memory controller and its pin stage.
// Assumes sram_port_map.svh is on the include path.
`include "sram_port_map.svh"

package sram_port_pkg;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`DATA_W-1:0] data_t;
  typedef logic [3:0]         cnt_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_WSET  = 3'b010,
    ST_WRITE = 3'b011,
    ST_WEND  = 3'b100,
    ST_TURN  = 3'b101,
    ST_SLEEP = 3'b110,
    ST_WAKE  = 3'b111
  } ctl_state_e;
endpackage

// ### hdl/sram_pin_if.sv
// Bundle of pin values decoded from the sequencer registers, passed to the pin stage.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
`default_nettype none
interface sram_pin_if;
  import sram_port_pkg::*;
  logic  cs_n;
  logic  we_n;
  logic  oe_n;
  logic  upper_lane_enable_n;
  logic  lower_lane_enable_n;
  addr_t addr;
  data_t wdata;
  logic  drive;
  modport seq (output cs_n, we_n, oe_n, upper_lane_enable_n, lower_lane_enable_n, addr, wdata, drive);
  modport pins (input cs_n, we_n, oe_n, upper_lane_enable_n, lower_lane_enable_n, addr, wdata, drive);
endinterface
`default_nettype wire

// ### hdl/sram_pin_stage.sv
// Output register stage: every memory pin leaves from a flip-flop.
// Assumes the sequencer already meets all pin timing by cycle counts.
`timescale 1ns/1ps
`default_nettype none
module sram_pin_stage
  import sram_port_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // Sequencer side
  sram_pin_if.pins  p,
  // Memory pins
  output var  logic mem_cs_n,
  output var  logic mem_we_n,
  output var  logic mem_oe_n,
  output var  logic upper_lane_enable_n,
  output var  logic lower_lane_enable_n,
  output var  addr_t mem_addr,
  output var  data_t mem_dq_o,
  output var  logic [1:0] mem_dq_oe
);
  // ----------------------------------------------------------------------------
  // Pin registers; strobes idle high so the memory rests deselected
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mem_cs_n            <= 1'b1;
      mem_we_n            <= 1'b1;
      mem_oe_n            <= 1'b1;
      upper_lane_enable_n <= 1'b1;
      lower_lane_enable_n <= 1'b1;
      mem_addr            <= 16'h0000;
      mem_dq_o            <= 16'h0000;
      mem_dq_oe           <= 2'h0;
    end else begin
      mem_cs_n            <= p.cs_n;
      mem_we_n            <= p.we_n;
      mem_oe_n            <= p.oe_n;
      upper_lane_enable_n <= p.upper_lane_enable_n;
      lower_lane_enable_n <= p.lower_lane_enable_n;
      mem_addr            <= p.addr;
      mem_dq_o            <= p.wdata;
      mem_dq_oe           <= {2{p.drive}};
    end
  end
endmodule
`default_nettype wire

// ### sim/sram_ctrl_asserts.sv
// Pin-timing checks for the static memory controller.
// Assumes it is bound to sram_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_asserts
  import sram_port_pkg::*;
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       arst_n,
  // Status
  input wire logic       rsp_valid,
  input wire logic       sleep_req,
  input wire logic       asleep,
  // Memory pins
  input wire logic       mem_cs_n,
  input wire logic       mem_we_n,
  input wire logic       mem_oe_n,
  input wire logic       upper_lane_enable_n,
  input wire logic       lower_lane_enable_n,
  input wire addr_t      mem_addr,
  input wire data_t      mem_dq_o,
  input wire logic [1:0] mem_dq_oe
);
  // ----------------------------------------------------------------
  // Pin relations
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Two registered cycles give 50 ns, above the 40 ns floor
  sequence s_pulse;
    !mem_we_n [*2];
  endsequence
  sequence s_read_open;
    (!mem_cs_n && !mem_oe_n && mem_we_n) [*3];
  endsequence
  a_no_bus_fight: assert property (mem_dq_oe != 2'b00 |-> mem_oe_n)
    else $error("controller drives data while memory may drive");
  a_write_qual: assert property (!mem_we_n |-> !mem_cs_n && !(upper_lane_enable_n && lower_lane_enable_n))
    else $error("write strobe without select or lane");
  a_write_pulse: assert property ($fell(mem_we_n) |-> s_pulse)
    else $error("write pulse too short");
  a_write_steady: assert property (!mem_we_n |-> mem_dq_oe == 2'b11 && $stable(mem_dq_o) && $stable(mem_addr))
    else $error("data or address moved inside write pulse");
  a_write_end: assert property ($rose(mem_we_n) |-> mem_dq_oe == 2'b11 && $stable(mem_addr))
    else $error("data or address dropped before write end");
  a_lanes_idle: assert property (mem_cs_n && $past(mem_cs_n) |-> $stable({upper_lane_enable_n, lower_lane_enable_n}))
    else $error("lane enables toggled while deselected");
  a_read_span: assert property ($fell(mem_oe_n) |-> s_read_open)
    else $error("read closed before access time");
  a_read_answer: assert property ($fell(mem_oe_n) |-> ##[3:6] rsp_valid)
    else $error("read answer missing");
  a_sleep_desel: assert property (asleep |-> mem_cs_n && mem_we_n)
    else $error("selected while in retention");
  a_wake_delay: assert property ($fell(sleep_req) && asleep |-> mem_cs_n [*4])
    else $error("access too soon after retention");
endmodule
bind sram_ctrl sram_ctrl_asserts u_chk (.mclk, .arst_n, .rsp_valid, .sleep_req, .asleep, .mem_cs_n, .mem_we_n,
  .mem_oe_n, .upper_lane_enable_n, .lower_lane_enable_n, .mem_addr, .mem_dq_o, .mem_dq_oe);
`default_nettype wire

// ### sim/sram_cell_model.sv
// Behavioural 64K x 16 static memory with byte lanes.
// Assumes the controller's data drive arrives split as dq_o/dq_oe.
`timescale 1ns/1ps
`default_nettype none
module sram_cell_model
  import sram_port_pkg::*;
#(
  parameter int DLY = 0
)(
  // Strobes and address
  input wire logic       cs_n,
  input wire logic       we_n,
  input wire logic       oe_n,
  input wire logic       upper_lane_enable_n,
  input wire logic       lower_lane_enable_n,
  input wire addr_t      addr,
  // Controller data drive
  input wire logic [1:0] dq_oe,
  input wire data_t      dq_o,
  // Resolved bus and fault flag
  output var data_t      dq,
  output var logic       clash
);
  // ----------------------------------------------------------------
  // Array and bus
  // ----------------------------------------------------------------
  data_t      mem [0:65535];
  data_t      q;
  data_t      d_lat;
  addr_t      a_lat;
  logic [1:0] l_lat;
  logic [1:0] drv;
  // Deselect, output disable and write all float the pins
  wire rd = !cs_n && we_n && !oe_n;
  wire wr = !cs_n && !we_n && (!upper_lane_enable_n || !lower_lane_enable_n);
  assign #DLY q = mem[addr];
  assign drv = rd ? ~{upper_lane_enable_n, lower_lane_enable_n} : 2'b00;
  // Floating lanes show the inverse, so a stale value never passes
  assign dq[15:8] = dq_oe[1] ? dq_o[15:8] : drv[1] ? q[15:8] : ~q[15:8];
  assign dq[7:0] = dq_oe[0] ? dq_o[7:0] : drv[0] ? q[7:0] : ~q[7:0];
  initial clash = 1'b0;
  always @* if (|(drv & dq_oe)) clash = 1'b1;
  // Follow the overlap; whichever strobe ends it commits the data
  always @* if (wr) begin
    d_lat = dq;
    a_lat = addr;
    l_lat = ~{upper_lane_enable_n, lower_lane_enable_n};
  end
  always @(negedge wr) begin
    if (l_lat[0] === 1'b1) mem[a_lat][7:0] = d_lat[7:0];
    if (l_lat[1] === 1'b1) mem[a_lat][15:8] = d_lat[15:8];
  end
endmodule
`default_nettype wire

// ### sim/async_sram_byte_lane_port_bench.sv
// Self-checking bench for sram_ctrl against the memory model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module async_sram_byte_lane_port_bench;
  import sram_port_pkg::*;
  logic mclk, arst_n, req_valid, req_write, sleep_req, req_ready, rsp_valid, asleep;
  logic cs_n, we_n, oe_n, un, ln, clash;
  logic [1:0] req_lanes, dq_oe;
  addr_t req_addr, maddr;
  data_t req_wdata, rdata, dq_o, dq;
  int fails, checks_done;
  sram_ctrl u_dut (.mclk, .arst_n, .req_valid, .req_write, .req_addr, .req_wdata, .req_lanes, .req_ready,
    .rsp_valid, .rsp_rdata(rdata), .sleep_req, .asleep, .mem_cs_n(cs_n), .mem_we_n(we_n), .mem_oe_n(oe_n),
    .upper_lane_enable_n(un), .lower_lane_enable_n(ln), .mem_addr(maddr), .mem_dq_o(dq_o),
    .mem_dq_oe(dq_oe), .mem_dq_i(dq));
  // Slowest access time, so a read wait that is too short returns stale data
  sram_cell_model #(.DLY(55)) u_mem (.cs_n, .we_n, .oe_n, .upper_lane_enable_n(un),
    .lower_lane_enable_n(ln), .addr(maddr), .dq_oe, .dq_o, .dq, .clash);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input data_t seen, input data_t exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  // One request, held until taken; read data returned
  task automatic access(input logic wr, input addr_t a, input data_t d, input logic [1:0] l, output data_t got);
    int n;
    got = 'x;
    @(posedge mclk);
    #2;
    {req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, wr, a, d, l};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 20);
    #2 req_valid = 1'b0;
    for (n = 0; n < 20 && !(req_ready === 1'b1 && n > 1); n++) begin
      @(posedge mclk);
      #1 if (rsp_valid === 1'b1) got = rdata;
    end
  endtask
  function automatic data_t mask(input data_t v, input logic [1:0] l);
    return v & {{8{l[1]}}, {8{l[0]}}};
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_lanes;
    data_t g;
    for (int l = 1; l < 4; l++) begin
      access(1'b1, 16'h0010, 16'h1234, 2'b11, g);
      access(1'b1, 16'h0010, 16'hCDEF, l[1:0], g);
      check(u_mem.mem[16'h0010], mask(16'hCDEF, l[1:0]) | mask(16'h1234, ~l[1:0]), "lane write");
      access(1'b0, 16'h0010, 16'h0000, l[1:0], g);
      check(g, mask(16'hCDEF, l[1:0]), "lane read");
    end
    $display("t_lanes done");
  endtask
  task automatic t_edges;
    data_t g;
    access(1'b1, 16'hFFFF, 16'hA55A, 2'b11, g);
    access(1'b1, 16'h0000, 16'h5AA5, 2'b11, g);
    access(1'b0, 16'hFFFF, 16'h0000, 2'b11, g);
    check(g, 16'hA55A, "top word");
    access(1'b0, 16'h0000, 16'h0000, 2'b11, g);
    check(g, 16'h5AA5, "bottom word");
    $display("t_edges done");
  endtask
  task automatic t_no_lanes;
    @(posedge mclk);
    #2 {req_valid, req_write, req_lanes} = {1'b1, 1'b1, 2'b00};
    repeat (8) @(posedge mclk) #1 check(cs_n, 1'b1, "select with no lane");
    check(req_ready, 1'b1, "idle with no lane");
    @(posedge mclk);
    #2 req_valid = 1'b0;
    $display("t_no_lanes done");
  endtask
  task automatic t_sleep;
    data_t g;
    int n;
    @(posedge mclk);
    #2 sleep_req = 1'b1;
    for (n = 0; n < 10 && asleep !== 1'b1; n++) @(posedge mclk) #1;
    check(asleep, 1'b1, "retention entered");
    @(posedge mclk);
    #2 {req_valid, req_write, req_lanes} = {1'b1, 1'b0, 2'b11};
    repeat (5) @(posedge mclk) #1 check(cs_n, 1'b1, "refused while asleep");
    check(req_ready, 1'b0, "not ready while asleep");
    @(posedge mclk);
    #2 {req_valid, sleep_req} = 2'b00;
    access(1'b0, 16'hFFFF, 16'h0000, 2'b11, g);
    check(g, 16'hA55A, "data kept");
    $display("t_sleep done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Clock and main sequence
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    {arst_n, req_valid, req_write, sleep_req, req_lanes, req_addr, req_wdata} = '0;
    repeat (6) @(posedge mclk);
    #2 arst_n = 1'b1;
    t_lanes();
    t_edges();
    t_no_lanes();
    t_sleep();
    check(clash, 1'b0, "bus fight");
    stop_test();
  end
  // Hang guard, far beyond the roughly 140 cycles needed
  initial begin
    #(3000 * 25);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
`default_nettype wire
